// file: hdl/cap_defines.svh
// Purpose: Register offsets, field positions, reset values and codes
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes: Included by the sensing controller files
`ifndef CAP_DEFINES_SVH
`define CAP_DEFINES_SVH
// ==========================================
// Register byte offsets
`define OFF_CTRL 6'h00
`define OFF_CFG 6'h04
`define OFF_MODE 6'h08
`define OFF_THRESH 6'h0C
`define OFF_SS 6'h10
`define OFF_SE 6'h14
`define OFF_MUX 6'h18
`define OFF_MASK 6'h1C
`define OFF_DATA 6'h20
// ==========================================
// Field positions
`define CTRL_EN 0
`define CTRL_BUSY 1
`define CTRL_HIT 2
`define CTRL_CIE 3
`define CFG_ACU 0
`define CFG_TRIG 4
`define CFG_SMEN 7
`define CFG_WOI 8
`define CFG_MCEN 9
`define MODE_GAIN 0
`define MODE_LEN 4
// ==========================================
// Reset values and codes
`define GAIN_RST 3'h7
`define LEN_RST 2'h1
`define TRIG_SW 3'h0
`define TRIG_CONT 3'h5
`define TRIG_SCAN 3'h7
`endif

// file: hdl/cap_pkg.sv
// Purpose: Types shared by the sensing controller modules
// Assumes: Nothing beyond the defines header
// Notes: Channel codes are five bits wide
package cap_pkg;
  typedef logic [4:0] chan_t;
  typedef enum logic [1:0] {ST_IDLE, ST_KICK, ST_WAIT, ST_RESULT} scan_state_e;
  typedef struct packed {
    scan_state_e st;
    logic en;
    logic busy;
    logic hit;
    logic cie;
    logic [2:0] acu;
    logic [2:0] trig;
    logic smen;
    logic woi;
    logic mcen;
    logic [2:0] gain;
    logic [1:0] len;
    logic [15:0] thresh;
    chan_t ss;
    chan_t se;
    chan_t mux;
    chan_t origin;
    logic [31:0] mask;
    logic [15:0] data;
    logic go;
    logic ack;
    logic [31:0] rdata;
    logic afe_start;
    logic [31:0] ground;
    logic [31:0] short_mask;
    logic conv_done;
    logic hit_evt;
    logic wake;
  } ctrl_s;
  typedef struct packed {
    logic [6:0] count;
    logic [21:0] sum;
    logic [15:0] result;
    logic hit;
    logic valid;
  } acc_s;
endpackage

// file: hdl/acc_if.sv
// Purpose: Link between the scan controller and the accumulator
// Assumes: Both ends on the same clock
// Notes: last is valid while a sample is offered
`timescale 1ns/10ps
interface acc_if;
  logic sample_valid;
  logic [15:0] sample;
  logic clear;
  logic [2:0] count_sel;
  logic [1:0] len_sel;
  logic [15:0] thresh;
  logic last;
  logic result_valid;
  logic [15:0] result;
  logic hit;
  modport ctrl(output sample_valid, sample, clear, count_sel, len_sel, thresh,
    input last, result_valid, result, hit);
  modport acc(input sample_valid, sample, clear, count_sel, len_sel, thresh,
    output last, result_valid, result, hit);
endinterface

// file: hdl/sample_accum.sv
// Purpose: Sum, average, truncate and compare conversion samples
// Assumes: Samples arrive as one-cycle strobes
// Notes: Result and hit come one cycle after the last sample
`timescale 1ns/10ps
`include "cap_defines.svh"
module sample_accum
  import cap_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic resetn,
  // Controller side
  acc_if.acc a
);
  acc_s q, d;

  // ==========================================
  // Helpers
  function automatic logic [2:0] shift_of(input logic [2:0] sel);
    unique case (sel)
      3'h0: shift_of = 3'h0;
      3'h1: shift_of = 3'h2;
      3'h2: shift_of = 3'h3;
      3'h3: shift_of = 3'h4;
      3'h4: shift_of = 3'h5;
      default: shift_of = 3'h6;
    endcase
  endfunction

  function automatic logic [15:0] len_mask(input logic [1:0] len);
    unique case (len)
      2'h0: len_mask = 16'hFFF0;
      2'h1: len_mask = 16'hFFF8;
      2'h2: len_mask = 16'hFFFC;
      default: len_mask = 16'hFFFF;
    endcase
  endfunction

  logic [21:0] sum_next;
  logic [6:0] target;
  assign sum_next = q.sum + {6'h00, a.sample};
  assign target = 7'h01 << shift_of(a.count_sel);
  assign a.last = (q.count + 7'h01) == target;

  // ==========================================
  // Accumulate and divide
  always_comb begin
    d = q;
    d.valid = 1'b0;
    if (a.clear) begin
      d.count = '0;
      d.sum = '0;
    end else if (a.sample_valid) begin
      if (a.last) begin
        d.result = 16'((sum_next >> shift_of(a.count_sel))) & len_mask(a.len_sel);
        d.hit = d.result > a.thresh;
        d.valid = 1'b1;
        d.count = '0;
        d.sum = '0;
      end else begin
        d.count = q.count + 7'h01;
        d.sum = sum_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign a.result_valid = q.valid;
  assign a.result = q.result;
  assign a.hit = q.hit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  trunc_bits_a: assert property (a.result_valid && a.len_sel == 2'h0 |-> a.result[3:0] == 4'h0)
    else $error("unconverted low bits not zero");
  cmp_flag_a: assert property (a.result_valid |-> a.hit == (a.result > $past(a.thresh)))
    else $error("threshold flag disagrees with result");
endmodule

// file: hdl/cap_scan_ctrl.sv
// Purpose: Capacitive sense control, triggers and channel auto-scan
// Assumes: Front end and timer strobes run on clk; registers on classic Wishbone
// Notes: Analog measurement itself lives outside this block
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "cap_defines.svh"
module cap_scan_ctrl
  import cap_pkg::*;
#(
  parameter int NUM_CH = 27
) (
  // System
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [5:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Trigger sources and debug
  input wire logic [3:0] timer_ovf,
  input wire logic debug_halt,
  // Analog front end
  input wire logic afe_done,
  input wire logic [15:0] afe_result,
  output logic afe_enable,
  output logic afe_start,
  output logic [4:0] afe_channel,
  output logic [2:0] afe_gain,
  output logic [1:0] afe_length,
  output logic [31:0] afe_short_mask,
  output logic [31:0] afe_ground_mask,
  // Events
  output logic conv_done,
  output logic cmp_hit,
  output logic wake
);
  if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_ch
    $error("NUM_CH must lie in 1..32");
  end

  // Channels at or above NUM_CH have no pin, so their mask bits stay 0
  localparam logic [31:0] CH_MASK = 32'((64'h1 << NUM_CH) - 64'h1);

  ctrl_s q, d;
  acc_if acc();

  sample_accum u_acc (
    .clk(clk),
    .resetn(resetn),
    .a(acc.acc)
  );

  // ==========================================
  // Decoders
  function automatic logic trig_fires(input logic [2:0] trig, input logic [3:0] ovf);
    unique case (trig)
      3'h1: trig_fires = ovf[0];
      3'h2: trig_fires = ovf[2];
      3'h3: trig_fires = ovf[1];
      3'h4: trig_fires = ovf[3];
      default: trig_fires = 1'b0;
    endcase
  endfunction

  function automatic logic range_mode(input ctrl_s s);
    range_mode = s.trig == `TRIG_SCAN && !s.smen;
  endfunction

  function automatic logic mask_mode(input ctrl_s s);
    mask_mode = s.smen && (s.trig == `TRIG_SCAN || s.trig == `TRIG_CONT);
  endfunction

  // Next masked channel after cur, wrapping; cur itself if no other is set
  function automatic chan_t next_masked(input chan_t cur, input logic [31:0] mask);
    chan_t idx;
    logic found;
    next_masked = cur;
    found = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      idx = chan_t'(32'(cur) + i);
      if (!found && 32'(idx) < NUM_CH && mask[idx]) begin
        next_masked = idx;
        found = 1'b1;
      end
    end
  endfunction

  function automatic logic [31:0] ground_of(input ctrl_s s);
    ground_of = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (range_mode(s) && 32'(s.ss) <= i && i <= 32'(s.se) && 32'(s.mux) != i) begin
        ground_of[i] = 1'b1;
      end
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] read_reg(input ctrl_s s, input logic [5:0] adr);
    read_reg = '0;
    unique case (adr)
      `OFF_CTRL: read_reg = {28'h0, s.cie, s.hit, s.busy, s.en};
      `OFF_CFG: read_reg = {22'h0, s.mcen, s.woi, s.smen, s.trig, 1'b0, s.acu};
      `OFF_MODE: read_reg = {26'h0, s.len, 1'b0, s.gain};
      `OFF_THRESH: read_reg = {16'h0, s.thresh};
      `OFF_SS: read_reg = {27'h0, s.ss};
      `OFF_SE: read_reg = {27'h0, s.se};
      `OFF_MUX: read_reg = {27'h0, s.mux};
      `OFF_MASK: read_reg = s.mask;
      `OFF_DATA: read_reg = {16'h0, s.data};
      default: read_reg = '0;
    endcase
  endfunction

  // ==========================================
  // Accumulator hookup
  assign acc.sample_valid = q.st == ST_WAIT && afe_done;
  assign acc.sample = afe_result;
  assign acc.clear = !q.en || q.st == ST_IDLE;
  assign acc.count_sel = q.acu;
  assign acc.len_sel = q.len;
  assign acc.thresh = q.thresh;

  logic req;
  logic wr;
  logic [31:0] wv;
  assign req = wb_cyc && wb_stb;
  assign wr = req && wb_we && q.ack;
  assign wv = merge(read_reg(q, wb_adr), wb_dat_w, wb_sel);

  // ==========================================
  // Next state
  always_comb begin
    d = q;
    d.afe_start = 1'b0;
    d.conv_done = 1'b0;
    d.hit_evt = 1'b0;
    d.wake = 1'b0;
    d.ack = req && !q.ack;
    d.rdata = req && !q.ack ? read_reg(q, wb_adr) : '0;
    unique case (q.st)
      ST_IDLE: begin
        // Continuous and scan modes only begin from a busy write
        if (q.go || trig_fires(q.trig, timer_ovf)) begin
          d.go = 1'b0;
          d.busy = 1'b1;
          d.origin = q.mux;
          d.st = ST_KICK;
        end
      end
      ST_KICK: begin
        d.afe_start = 1'b1;
        d.ground = ground_of(q);
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (afe_done) begin
          d.st = acc.last ? ST_RESULT : ST_KICK;
        end
      end
      ST_RESULT: begin
        if (acc.result_valid) begin
          d.data = acc.result;
          d.hit = acc.hit;
          d.conv_done = q.cie;
          d.hit_evt = acc.hit;
          d.wake = acc.hit || q.thresh == 16'h0000;
          d.st = ST_IDLE;
          d.busy = 1'b0;
          d.ground = '0;
          if ((range_mode(q) || mask_mode(q)) && acc.hit) begin
            // Stop with mux on the touched channel
            d.st = ST_IDLE;
          end else if (range_mode(q)) begin
            if (q.mux == q.se) begin
              d.mux = q.ss;
              if (!debug_halt) begin
                d.st = ST_KICK;
                d.busy = 1'b1;
              end
            end else begin
              d.mux = q.mux + 5'h01;
              d.st = ST_KICK;
              d.busy = 1'b1;
            end
          end else if (mask_mode(q)) begin
            if (next_masked(q.mux, q.mask) == q.origin) begin
              d.wake = d.wake || q.woi;
            end else begin
              d.mux = next_masked(q.mux, q.mask);
              d.st = ST_KICK;
              d.busy = 1'b1;
            end
          end else if (q.trig == `TRIG_CONT) begin
            d.st = ST_KICK;
            d.busy = 1'b1;
          end
        end
      end
    endcase
    if (!q.en) begin
      d.st = ST_IDLE;
      d.busy = 1'b0;
      // A kick caught by the enable drop must not reach the front end
      d.afe_start = 1'b0;
      d.ground = '0;
    end
    // Bus writes last so a busy write beats a same-cycle stop
    if (wr) begin
      unique case (wb_adr)
        `OFF_CTRL: begin
          d.en = wv[`CTRL_EN];
          d.cie = wv[`CTRL_CIE];
          if (wv[`CTRL_BUSY]) begin
            d.go = 1'b1;
          end
        end
        `OFF_CFG: begin
          d.acu = wv[`CFG_ACU +: 3];
          d.trig = wv[`CFG_TRIG +: 3];
          d.smen = wv[`CFG_SMEN];
          d.woi = wv[`CFG_WOI];
          d.mcen = wv[`CFG_MCEN];
        end
        `OFF_MODE: begin
          d.gain = wv[`MODE_GAIN +: 3];
          d.len = wv[`MODE_LEN +: 2];
        end
        `OFF_THRESH: d.thresh = wv[15:0];
        `OFF_SS: begin
          d.ss = wv[4:0];
          if (range_mode(q) || mask_mode(q)) begin
            d.mux = wv[4:0];
          end
        end
        `OFF_SE: d.se = wv[4:0];
        `OFF_MUX: d.mux = wv[4:0];
        `OFF_MASK: d.mask = wv & CH_MASK;
        default: d.go = d.go;
      endcase
    end
    // Registered so the pins see the new mask together with the mode bit
    d.short_mask = d.mcen ? d.mask : '0;
  end

  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.gain <= `GAIN_RST;
      q.len <= `LEN_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs, all straight from flops
  assign wb_ack = q.ack;
  assign wb_dat_r = q.rdata;
  assign afe_enable = q.en;
  assign afe_start = q.afe_start;
  assign afe_channel = q.mux;
  assign afe_gain = q.gain;
  assign afe_length = q.len;
  // Mask reaches the pins only while multi-channel mode is on
  assign afe_short_mask = q.short_mask;
  assign afe_ground_mask = q.ground;
  assign conv_done = q.conv_done;
  assign cmp_hit = q.hit_evt;
  assign wake = q.wake;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence result_s;
    q.st == ST_RESULT && acc.result_valid;
  endsequence
  sequence scan_hit_s;
    result_s and (acc.hit && (range_mode(q) || mask_mode(q)));
  endsequence

  bus_ack_a: assert property (req && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("ack not one cycle after request");
  shut_down_a: assert property (!q.en |=> q.st == ST_IDLE && !afe_start && !q.busy)
    else $error("unit active while disabled");
  start_busy_a: assert property (afe_start |-> q.busy)
    else $error("conversion started without busy");
  done_event_a: assert property (result_s and q.cie |=> conv_done && q.data == $past(acc.result))
    else $error("completion event missing");
  hit_stop_a: assert property (scan_hit_s |=> q.st == ST_IDLE ##1 !afe_start)
    else $error("scan continued after hit");
  range_wrap_a: assert property (result_s and (range_mode(q) && !acc.hit && q.mux == q.se)
                                 |=> afe_channel == $past(q.ss))
    else $error("range scan did not reload start");
  range_step_a: assert property (result_s and (range_mode(q) && !acc.hit && q.mux != q.se)
                                 |=> afe_channel == $past(q.mux) + 5'h01 ##1 (afe_start || !afe_enable))
    else $error("range scan did not step and start");
  ss_copy_a: assert property (wr && wb_adr == `OFF_SS && wb_sel[0] && (range_mode(q) || mask_mode(q))
                              |=> afe_channel == $past(wb_dat_w[4:0]))
    else $error("start channel not copied to mux");
  zero_wake_a: assert property (result_s and q.thresh == 16'h0000 |=> wake)
    else $error("zero threshold did not wake");
endmodule

// file: verif/afe_model.sv
// Purpose: Behavioural analog front end that answers conversion starts
// Assumes: Same clock as the controller; start is a one-cycle pulse
// Notes: Outside its valid cycle the result shows the inverse of the last sample
`timescale 1ns/10ps
module afe_model (
  // System
  input wire logic clk,
  input wire logic resetn,
  // Controller side
  input wire logic afe_enable,
  input wire logic afe_start,
  input wire logic [4:0] afe_channel,
  output logic afe_done,
  output logic [15:0] afe_result,
  // Bench control
  input wire logic [4:0] hit_ch,
  input wire logic [15:0] base
);
  logic [1:0] wait_q;
  logic run_q;
  logic odd_q;
  logic [15:0] last_q;
  logic [15:0] val;
  // Every channel but hit_ch answers as a correctly configured analog input, hit_ch reads 16'hFFF0; odd samples sit 16 higher
  assign val = (afe_channel == hit_ch) ? 16'hFFF0 : base + (odd_q ? 16'h0010 : 16'h0000);
  always @(posedge clk) begin
    afe_done <= 1'b0;
    afe_result <= ~last_q;
    if (!resetn) begin
      run_q <= 1'b0;
      odd_q <= 1'b0;
      last_q <= 16'h0000;
    end else if (afe_start && afe_enable) begin
      run_q <= 1'b1;
      wait_q <= 2'h2;
    end else if (run_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (run_q) begin
      run_q <= 1'b0;
      odd_q <= ~odd_q;
      last_q <= val;
      afe_done <= 1'b1;
      afe_result <= val;
    end
  end
endmodule

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the sensing scan controller
// Assumes: Front end model answers three cycles after each start
// Notes: Debug halt is raised once, mid range scan, to end the rotation
`timescale 1ns/10ps
`include "cap_defines.svh"
module tb_top
  import cap_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [3:0] timer_ovf = 4'h0;
  logic debug_halt = 1'b0;
  logic afe_done, afe_enable, afe_start, conv_done, cmp_hit, wake;
  logic [15:0] afe_result;
  logic [4:0] afe_channel;
  logic [2:0] afe_gain;
  logic [1:0] afe_length;
  logic [31:0] afe_short_mask, afe_ground_mask;
  logic [15:0] base = 16'h0100;
  chan_t hit_ch = 5'h1F;
  logic [31:0] rnd = 32'hB7441E69;
  logic [31:0] rd;
  logic [3:0] tmr [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
  chan_t mseq [3] = '{5'h05, 5'h09, 5'h01};
  chan_t seen [$];
  logic saw_done, saw_hit, saw_wake, gnd_on;
  int mismatches = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  cap_scan_ctrl #(.NUM_CH(27)) u_cap_scan_ctrl (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .timer_ovf(timer_ovf), .debug_halt(debug_halt), .afe_done(afe_done), .afe_result(afe_result),
    .afe_enable(afe_enable), .afe_start(afe_start), .afe_channel(afe_channel), .afe_gain(afe_gain),
    .afe_length(afe_length), .afe_short_mask(afe_short_mask), .afe_ground_mask(afe_ground_mask),
    .conv_done(conv_done), .cmp_hit(cmp_hit), .wake(wake));
  afe_model u_afe_model (.clk(clk), .resetn(resetn), .afe_enable(afe_enable), .afe_start(afe_start),
    .afe_channel(afe_channel), .afe_done(afe_done), .afe_result(afe_result), .hit_ch(hit_ch), .base(base));
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] trunc(input logic [15:0] v, input int len);
    logic [15:0] m [4] = '{16'hFFF0, 16'hFFF8, 16'hFFFC, 16'hFFFF};
    return v & m[len];
  endfunction
  function automatic logic [31:0] gmask(input chan_t c);
    logic [31:0] m = 32'h1C;
    m[c] = 1'b0;
    return m;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // Classic single cycle; the master waits for ack and never assumes a latency
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    rd = wb_dat_r;
    if (n >= 40) mismatches++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Stop codes: 1 completion, 2 threshold hit, 3 wake; 0 runs the full span
  task automatic watch(input int ncyc, input int stop);
    seen.delete();
    saw_done = 1'b0;
    saw_hit = 1'b0;
    saw_wake = 1'b0;
    for (int i = 0; i < ncyc; i++) begin
      @(posedge clk);
      if (afe_start === 1'b1 && gnd_on) chk(afe_ground_mask, gmask(afe_channel));
      if (afe_start === 1'b1) seen.push_back(afe_channel);
      saw_done |= (conv_done === 1'b1);
      saw_hit |= (cmp_hit === 1'b1);
      saw_wake |= (wake === 1'b1);
      if ((stop == 1 && saw_done) || (stop == 2 && saw_hit) || (stop == 3 && saw_wake)) break;
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // ==========================================
  // Main sequence
  initial begin
    gnd_on = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(afe_gain, 3'h7);
    chk(afe_length, 2'h1);
    chk(afe_enable, 1'b0);
    wb(`OFF_MODE, 1'b0, 32'h0);
    chk(rd, 32'h17);
    wb(`OFF_CTRL, 1'b1, 32'h9);
    wb(`OFF_CFG, 1'b1, 32'h1);
    wb(`OFF_THRESH, 1'b1, 32'hFFFF);
    chk(afe_enable, 1'b1);
    for (int len = 0; len < 4; len++) begin
      rnd = lfsr(rnd);
      base <= (rnd[15:0] & 16'h7FF0) | 16'h0100;
      wb(`OFF_MODE, 1'b1, 32'h7 | (len << 4));
      wb(`OFF_CTRL, 1'b1, 32'hB);
      watch(200, 1);
      chk(seen.size(), 4);
      chk(afe_length, len);
      wb(`OFF_DATA, 1'b0, 32'h0);
      chk(rd, trunc(base + 16'h8, len));
      wb(`OFF_CTRL, 1'b0, 32'h0);
      chk(rd, 32'h9);
    end
    wb(`OFF_CFG, 1'b1, 32'h0);
    wb(`OFF_THRESH, 1'b1, base);
    for (int k = 0; k < 2; k++) begin
      wb(`OFF_CTRL, 1'b1, 32'hB);
      watch(100, 1);
      chk(saw_hit, k);
      chk(saw_wake, k);
    end
    wb(`OFF_THRESH, 1'b1, 32'h0);
    wb(`OFF_CTRL, 1'b1, 32'hB);
    watch(100, 1);
    chk(saw_wake, 1'b1);
    for (int c = 1; c < 5; c++) begin
      wb(`OFF_CFG, 1'b1, c << 4);
      timer_ovf <= tmr[c - 1] ^ 4'hF;
      @(posedge clk);
      timer_ovf <= 4'h0;
      watch(8, 0);
      chk(seen.size(), 0);
      timer_ovf <= tmr[c - 1];
      @(posedge clk);
      timer_ovf <= 4'h0;
      watch(100, 1);
      chk(seen.size(), 1);
    end
    wb(`OFF_CFG, 1'b1, 32'h50);
    watch(12, 0);
    chk(seen.size(), 0);
    wb(`OFF_CTRL, 1'b1, 32'hB);
    watch(60, 0);
    chk(seen.size() >= 3, 1'b1);
    wb(`OFF_CTRL, 1'b1, 32'h0);
    watch(20, 0);
    chk(seen.size(), 0);
    chk(afe_enable, 1'b0);
    wb(`OFF_CTRL, 1'b1, 32'h9);
    rnd = lfsr(rnd);
    wb(`OFF_MASK, 1'b1, rnd);
    wb(`OFF_CFG, 1'b1, 32'h200);
    repeat (2) @(posedge clk);
    chk(afe_short_mask, rnd & 32'h07FFFFFF);
    wb(`OFF_CFG, 1'b1, 32'h70);
    repeat (2) @(posedge clk);
    chk(afe_short_mask, 32'h0);
    wb(`OFF_THRESH, 1'b1, 32'h8000);
    wb(`OFF_SE, 1'b1, 32'h4);
    wb(`OFF_SS, 1'b1, 32'h2);
    wb(`OFF_MUX, 1'b0, 32'h0);
    chk(rd, 32'h2);
    gnd_on = 1'b1;
    wb(`OFF_CTRL, 1'b1, 32'hB);
    watch(60, 0);
    gnd_on = 1'b0;
    for (int i = 0; i < 5; i++) chk(seen[i], 2 + i % 3);
    hit_ch <= 5'h03;
    watch(100, 2);
    chk(saw_hit, 1'b1);
    repeat (2) @(posedge clk);
    wb(`OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'hD);
    wb(`OFF_MUX, 1'b0, 32'h0);
    chk(rd, 32'h3);
    watch(20, 0);
    chk(seen.size(), 0);
    hit_ch <= 5'h1F;
    wb(`OFF_CTRL, 1'b1, 32'hB);
    watch(40, 0);
    chk(seen.size() > 0, 1'b1);
    debug_halt <= 1'b1;
    watch(60, 0);
    watch(20, 0);
    chk(seen.size(), 0);
    wb(`OFF_MUX, 1'b0, 32'h0);
    chk(rd, 32'h2);
    wb(`OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h9);
    debug_halt <= 1'b0;
    wb(`OFF_CTRL, 1'b1, 32'h0);
    wb(`OFF_CTRL, 1'b1, 32'h9);
    wb(`OFF_MASK, 1'b1, 32'h222);
    wb(`OFF_CFG, 1'b1, 32'h1D0);
    wb(`OFF_SS, 1'b1, 32'h5);
    wb(`OFF_CTRL, 1'b1, 32'hB);
    watch(150, 3);
    chk(seen.size(), 3);
    for (int i = 0; i < 3; i++) chk(seen[i], mseq[i]);
    chk(saw_wake, 1'b1);
    repeat (2) @(posedge clk);
    wb(`OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h9);
    wb(`OFF_SS, 1'b1, 32'h5);
    hit_ch <= 5'h09;
    wb(`OFF_CTRL, 1'b1, 32'hB);
    watch(150, 2);
    chk(seen.size(), 2);
    repeat (2) @(posedge clk);
    wb(`OFF_MUX, 1'b0, 32'h0);
    chk(rd, 32'h9);
    wb(`OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'hD);
    summarize();
  end
endmodule
